/* File: hw/cmd_interp_defines.vh */
`ifndef CMD_INTERP_DEFINES_VH
`define CMD_INTERP_DEFINES_VH

// queue and memory geometry
`define QUEUE_DEPTH 64
`define QUEUE_AW 6
`define CNT_W 7
`define MACRO_AW 9
`define MACRO_WORDS 512
`define USER_MACRO_WORDS 256
`define ROM_MACRO_BASE 9'h100
`define CFG_AW 9
`define CFG_BYTES 512
`define COPY_LAST 7'h3f

// command word fields, bit 15 is the msb
`define CMD_W 16
`define SUB_MSB 15
`define SUB_LSB 13
`define FLD_HI_MSB 12
`define FLD_HI_LSB 8
`define CODE_DST_MSB 11
`define CODE_SRC_MSB 3

// sub-address codes
`define SUB_TP1 3'h0
`define SUB_TP2 3'h1
`define SUB_TE1 3'h2
`define SUB_TE2 3'h3
`define SUB_CPU 3'h4
`define SUB_SPARE 3'h5
`define SUB_COPY 3'h6
`define SUB_MISC 3'h7

// table blocks of 32 bytes; copy codes 0,2,4,6,8 address pairs of them
`define BLK_TP1 4'h6
`define BLK_TE1 4'h7
`define BLK_TP2 4'h8
`define BLK_TE2 4'h9
`define BLK_CPU 4'ha

// miscellaneous handler indices handled inside the block
`define MISC_MACRO 5'h01
`define MISC_DELAY 5'h1e

// modechange tokens
`define TOKEN_CUTOFF 8'h01
`define TOKEN_BATDIS 8'h02
`define TOKEN_SOT 8'h03
`define SOT_SKIPPED_FLAG 8'h80

// apb register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_HISTORY 8'h08
`define REG_MACRO_ADDR 8'h0c
`define REG_MACRO_DATA 8'h10
`define REG_CFG_ADDR 8'h14
`define REG_CFG_DATA 8'h18
`define CTRL_RUN_BIT 0
`define CTRL_RESET 1'b1

`endif

/* File: hw/ram_sync_1r1w.v */
`default_nettype none

// simple dual port memory, one write port, registered read data
module ram_sync_1r1w #(
  parameter WIDTH = 16,
  parameter DEPTH = 64,
  parameter AW = 6
) (
  input wire clk_in, // memory clock
  input wire wr_en_in, // write strobe
  input wire [AW-1:0] wr_addr_in, // write address
  input wire [WIDTH-1:0] wr_data_in, // write data
  input wire [AW-1:0] rd_addr_in, // read address
  output reg [WIDTH-1:0] rd_data_out // read data, one cycle late
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage, no reset on purpose

  // write and registered read; same-address read returns old data
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end

endmodule // ram_sync_1r1w

`default_nettype wire

/* File: hw/serial_command_interpreter.v */
// Contract
// - top three bits pick update, copy or misc
// - empty queue stops; else run until hold
// - nonzero delay counter holds off processing
// - update offset is bits 12..8
// - update value is the low byte
// - update writes all three stored copies
// - camera table updates forwarded to camera link
// - copy destination bits 11..8, source 3..0
// - copy codes 0,2,4,6,8 name the tables
// - copy moves processor and electronics settings together
// - misc bits 12..8 index the handler table
// - misc low byte goes to handler
// - macro command loads stored macro into queue
// - user macro area 256 words, kept intact
// - each scheduler tick that finds the sequencer idle checks for pending token
// - cutoff and batdis tokens at once, others after queue
// - token selects rom macro headed by count
// - raise count, shift back, copy to head
// - tokens logged in four entry history
// - skipped start token logged with other code
// - queue holds 64 words, excess discarded
// - queued delay suspends all command processing
`include "cmd_interp_defines.vh"
`default_nettype none

module serial_command_interpreter (
  input wire mclk_in, // 250 mhz clock
  input wire reset_n_in, // async reset, active low
  input wire psel_in, // apb select
  input wire penable_in, // apb enable
  input wire pwrite_in, // apb direction
  input wire [7:0] paddr_in, // apb byte address
  input wire [31:0] pwdata_in, // apb write data
  output reg [31:0] prdata_out, // apb read data
  output reg pready_out, // apb ready
  output reg pslverr_out, // apb error, unmapped address
  input wire sched_tick_in, // scheduler cycle pulse
  input wire cmd_valid_in, // spacecraft bus command word strobe
  input wire [15:0] cmd_word_in, // spacecraft bus command word
  input wire bus_token_valid_in, // modechange token from bus
  input wire [7:0] bus_token_in, // bus token value
  input wire monitor_token_valid_in, // token from background monitor
  input wire [7:0] monitor_token_in, // monitor token value
  input wire sot_inhibit_in, // start tokens not performed now
  input wire tp_hold_in, // processor link busy, hold queue
  output reg misc_strobe_out, // dispatch pulse to a handler
  output reg [4:0] misc_index_out, // handler index
  output reg [7:0] misc_param_out, // handler parameter
  output reg te_link_strobe_out, // camera table update forward
  output reg te_link_unit_out, // 0 camera one, 1 camera two
  output reg [4:0] te_link_offset_out, // forwarded byte offset
  output reg [7:0] te_link_value_out, // forwarded byte value
  output reg cmd_dropped_out // pulse, incoming word discarded
);

  // fsm states
  localparam S_IDLE = 4'h0;
  localparam S_RUN = 4'h1;
  localparam S_EXEC = 4'h2;
  localparam S_CP_RD = 4'h3;
  localparam S_CP_WR = 4'h4;
  localparam S_MH_RD = 4'h5;
  localparam S_MH_LEN = 4'h6;
  localparam S_MC_RD = 4'h7;
  localparam S_MC_WR = 4'h8;
  localparam S_TOK = 4'h9;

  // majority vote of the three stored copies
  function [7:0] vote;
    input [7:0] a;
    input [7:0] b;
    input [7:0] c;
    begin
      vote = (a & b) | (a & c) | (b & c);
    end
  endfunction

  // table block addressed by an update sub-address
  function [3:0] blk_of;
    input [2:0] sub;
    begin
      case (sub)
        `SUB_TP1: blk_of = `BLK_TP1;
        `SUB_TP2: blk_of = `BLK_TP2;
        `SUB_TE1: blk_of = `BLK_TE1;
        `SUB_TE2: blk_of = `BLK_TE2;
        default: blk_of = `BLK_CPU;
      endcase
    end
  endfunction

  reg [3:0] st_q; // fsm state
  reg [`CNT_W-1:0] count_q; // queued words
  reg [`QUEUE_AW-1:0] head_q; // queue head index
  reg [7:0] delay_q; // queue delay, scheduler cycles
  reg tok_pend_q; // token waiting
  reg [7:0] tok_q; // waiting token value
  reg [31:0] hist_q; // four token history, newest low
  reg [`MACRO_AW-1:0] mac_ptr_q; // macro read pointer
  reg user_mac_q; // header gives bytes, not commands
  reg [`CNT_W-1:0] n_q; // words to insert
  reg [`CNT_W-1:0] k_q; // insert or copy step
  reg [`CFG_AW-1:0] src_q; // copy source pointer
  reg [`CFG_AW-1:0] dst_q; // copy destination pointer
  reg run_q; // software run enable
  reg [`MACRO_AW-1:0] mac_addr_q; // software macro load address
  reg [`CFG_AW-1:0] cfg_addr_q; // software table address
  reg cfg_ok_q; // table port free for software

  wire [15:0] q_rd; // word at queue head
  wire [15:0] mac_rd; // macro word
  wire [7:0] cfg_rd0; // stored copy 0
  wire [7:0] cfg_rd1; // stored copy 1
  wire [7:0] cfg_rd2; // stored copy 2
  wire [7:0] cfg_vote = vote(cfg_rd0, cfg_rd1, cfg_rd2); // voted byte

  // command word fields
  wire [2:0] sub = q_rd[`SUB_MSB:`SUB_LSB];
  wire [4:0] fld_hi = q_rd[`FLD_HI_MSB:`FLD_HI_LSB];
  wire [7:0] fld_lo = q_rd[7:0];
  wire [3:0] dst_code = q_rd[`CODE_DST_MSB:`FLD_HI_LSB];
  wire [3:0] src_code = q_rd[`CODE_SRC_MSB:0];
  wire is_update = (st_q == S_EXEC) && (sub <= `SUB_CPU);

  // incoming words land at the tail unless the queue is full
  wire q_full = (count_q == `QUEUE_DEPTH);
  wire in_wr = cmd_valid_in && !q_full;
  wire [`QUEUE_AW-1:0] tail = head_q + count_q[`QUEUE_AW-1:0];

  // macro copy yields the write port to incoming words
  wire mc_wr = (st_q == S_MC_WR) && !in_wr;
  wire q_we = in_wr || mc_wr;
  wire [`QUEUE_AW-1:0] q_waddr = in_wr ? tail :
    head_q + k_q[`QUEUE_AW-1:0];

  // apb decode; writes and reads take effect on the ready edge
  wire apb_acc = psel_in && penable_in && !pready_out;
  wire apb_done = psel_in && penable_in && pready_out;
  wire apb_wr = apb_done && pwrite_in;
  wire is_cfg_data = (paddr_in == `REG_CFG_DATA);
  wire apb_cfg_we = apb_wr && is_cfg_data;
  wire apb_mac_we = apb_wr && (paddr_in == `REG_MACRO_DATA);
  wire mapped = (paddr_in == `REG_CTRL) || (paddr_in == `REG_STATUS) ||
    (paddr_in == `REG_HISTORY) || (paddr_in == `REG_MACRO_ADDR) ||
    (paddr_in == `REG_MACRO_DATA) || (paddr_in == `REG_CFG_ADDR) ||
    is_cfg_data;

  // table port: one write drives all three copies
  wire cfg_we = is_update || (st_q == S_CP_WR) || apb_cfg_we;
  wire [`CFG_AW-1:0] cfg_waddr = is_update ? {blk_of(sub), fld_hi} :
    (st_q == S_CP_WR) ? dst_q : cfg_addr_q;
  wire [7:0] cfg_wdata = is_update ? fld_lo :
    (st_q == S_CP_WR) ? cfg_vote : pwdata_in[7:0];
  wire [`CFG_AW-1:0] cfg_raddr = (st_q == S_IDLE) ? cfg_addr_q : src_q;

  // header length in words; user macros count bytes
  wire [15:0] hdr_words = user_mac_q ? {1'b0, mac_rd[15:1]} : mac_rd;
  wire [16:0] fill = {10'h000, count_q} + {1'b0, hdr_words} +
    {16'h0000, in_wr};
  wire ins_ok = (hdr_words != 16'h0000) &&
    (fill <= `QUEUE_DEPTH);
  wire ins = (st_q == S_MH_LEN) && ins_ok;
  wire pop = (st_q == S_EXEC);
  wire hi_prio = (tok_q == `TOKEN_CUTOFF) || (tok_q == `TOKEN_BATDIS);
  wire sot_skip = (tok_q == `TOKEN_SOT) && sot_inhibit_in;

  // queue storage, 64 words
  ram_sync_1r1w #(.WIDTH(`CMD_W), .DEPTH(`QUEUE_DEPTH),
    .AW(`QUEUE_AW)) queue_mem (
    .clk_in(mclk_in),
    .wr_en_in(q_we),
    .wr_addr_in(q_waddr),
    .wr_data_in(in_wr ? cmd_word_in : mac_rd),
    .rd_addr_in(head_q),
    .rd_data_out(q_rd)
  );

  // macro store: low half user area, not voted; high half rom image
  ram_sync_1r1w #(.WIDTH(`CMD_W), .DEPTH(`MACRO_WORDS),
    .AW(`MACRO_AW)) macro_mem (
    .clk_in(mclk_in),
    .wr_en_in(apb_mac_we),
    .wr_addr_in(mac_addr_q),
    .wr_data_in(pwdata_in[15:0]),
    .rd_addr_in(mac_ptr_q),
    .rd_data_out(mac_rd)
  );

  // three redundant table copies, read through the vote
  ram_sync_1r1w #(.WIDTH(8), .DEPTH(`CFG_BYTES), .AW(`CFG_AW)) cfg0 (
    .clk_in(mclk_in),
    .wr_en_in(cfg_we),
    .wr_addr_in(cfg_waddr),
    .wr_data_in(cfg_wdata),
    .rd_addr_in(cfg_raddr),
    .rd_data_out(cfg_rd0)
  );
  ram_sync_1r1w #(.WIDTH(8), .DEPTH(`CFG_BYTES), .AW(`CFG_AW)) cfg1 (
    .clk_in(mclk_in),
    .wr_en_in(cfg_we),
    .wr_addr_in(cfg_waddr),
    .wr_data_in(cfg_wdata),
    .rd_addr_in(cfg_raddr),
    .rd_data_out(cfg_rd1)
  );
  ram_sync_1r1w #(.WIDTH(8), .DEPTH(`CFG_BYTES), .AW(`CFG_AW)) cfg2 (
    .clk_in(mclk_in),
    .wr_en_in(cfg_we),
    .wr_addr_in(cfg_waddr),
    .wr_data_in(cfg_wdata),
    .rd_addr_in(cfg_raddr),
    .rd_data_out(cfg_rd2)
  );

  // queue count and head; count and head move on the same edge
  // so an incoming word never lands between the two steps
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_q <= {`CNT_W{1'b0}};
      head_q <= {`QUEUE_AW{1'b0}};
    end else begin
      if (ins) begin
        // count raised and entries shifted back by moving head, both on one edge
        count_q <= count_q + hdr_words[`CNT_W-1:0] +
          {{(`CNT_W-1){1'b0}}, in_wr};
        head_q <= head_q - hdr_words[`QUEUE_AW-1:0];
      end else if (pop) begin
        count_q <= count_q - {{(`CNT_W-1){1'b0}}, !in_wr};
        head_q <= head_q + 6'h01;
      end else begin
        count_q <= count_q + {{(`CNT_W-1){1'b0}}, in_wr};
      end
    end
  end

  // token capture; a new token wins over the clear
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tok_pend_q <= 1'b0;
      tok_q <= 8'h00;
    end else if (bus_token_valid_in) begin
      tok_pend_q <= 1'b1;
      tok_q <= bus_token_in;
    end else if (monitor_token_valid_in) begin
      tok_pend_q <= 1'b1;
      tok_q <= monitor_token_in;
    end else if (st_q == S_TOK) begin
      tok_pend_q <= 1'b0;
    end
  end

  // queue delay counter, counted in scheduler cycles
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      delay_q <= 8'h00;
    end else if (pop && sub == `SUB_MISC && fld_hi == `MISC_DELAY) begin
      delay_q <= fld_lo;
    end else if (sched_tick_in && delay_q != 8'h00) begin
      delay_q <= delay_q - 8'h01;
    end
  end

  // main sequencer
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= S_IDLE;
      hist_q <= 32'h0000_0000;
      mac_ptr_q <= {`MACRO_AW{1'b0}};
      user_mac_q <= 1'b0;
      n_q <= {`CNT_W{1'b0}};
      k_q <= {`CNT_W{1'b0}};
      src_q <= {`CFG_AW{1'b0}};
      dst_q <= {`CFG_AW{1'b0}};
    end else begin
      case (st_q)
        S_IDLE: begin
          // token check happens on each scheduler tick that finds the sequencer idle
          if (sched_tick_in) begin
            if (tok_pend_q && (hi_prio || count_q == 7'h00)) begin
              st_q <= S_TOK;
            end else begin
              st_q <= S_RUN;
            end
          end
        end
        S_RUN: begin
          // head word is valid one cycle later, in S_EXEC; stop on empty or any hold
          if (count_q == 7'h00 || delay_q != 8'h00 || tp_hold_in ||
              !run_q) begin
            st_q <= S_IDLE;
          end else begin
            st_q <= S_EXEC;
          end
        end
        S_EXEC: begin
          // every command is one word; updates write in this cycle
          st_q <= S_RUN;
          if (sub == `SUB_COPY) begin
            // a code selects 64 bytes: processor then camera block
            src_q <= {src_code, 5'h00};
            dst_q <= {dst_code, 5'h00};
            k_q <= {`CNT_W{1'b0}};
            st_q <= S_CP_RD;
          end else if (sub == `SUB_MISC && fld_hi == `MISC_MACRO) begin
            mac_ptr_q <= {1'b0, fld_lo};
            user_mac_q <= 1'b1;
            st_q <= S_MH_RD;
          end
        end
        S_CP_RD: begin
          st_q <= S_CP_WR; // read latency
        end
        S_CP_WR: begin
          // voted source byte is written to all copies
          src_q <= src_q + 9'h001;
          dst_q <= dst_q + 9'h001;
          k_q <= k_q + 7'h01;
          st_q <= (k_q == `COPY_LAST) ? S_RUN : S_CP_RD;
        end
        S_MH_RD: begin
          st_q <= S_MH_LEN; // header read latency
        end
        S_MH_LEN: begin
          // refuse a block that would overflow; nothing is inserted
          n_q <= hdr_words[`CNT_W-1:0];
          k_q <= {`CNT_W{1'b0}};
          mac_ptr_q <= mac_ptr_q + 9'h001;
          st_q <= ins_ok ? S_MC_RD : S_RUN;
        end
        S_MC_RD: begin
          st_q <= S_MC_WR; // macro word read latency
        end
        S_MC_WR: begin
          // stall while incoming words own the queue write port
          if (mc_wr) begin
            mac_ptr_q <= mac_ptr_q + 9'h001;
            k_q <= k_q + 7'h01;
            st_q <= (k_q + 7'h01 == n_q) ? S_RUN : S_MC_RD;
          end
        end
        S_TOK: begin
          // log the token; a skipped start token is marked
          if (sot_skip) begin
            hist_q <= {hist_q[23:0],
              tok_q | `SOT_SKIPPED_FLAG};
            st_q <= S_RUN;
          end else begin
            hist_q <= {hist_q[23:0], tok_q};
            mac_ptr_q <= `ROM_MACRO_BASE |
              {1'b0, tok_q[3:0], 4'h0};
            user_mac_q <= 1'b0;
            st_q <= S_MH_RD;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // handler dispatch and camera link forwarding, one-cycle pulses
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      misc_strobe_out <= 1'b0;
      misc_index_out <= 5'h00;
      misc_param_out <= 8'h00;
      te_link_strobe_out <= 1'b0;
      te_link_unit_out <= 1'b0;
      te_link_offset_out <= 5'h00;
      te_link_value_out <= 8'h00;
      cmd_dropped_out <= 1'b0;
    end else begin
      cmd_dropped_out <= cmd_valid_in && q_full;
      misc_strobe_out <= pop && sub == `SUB_MISC &&
        fld_hi != `MISC_MACRO && fld_hi != `MISC_DELAY;
      // macro and delay commands leave the handler outputs alone
      if (pop && sub == `SUB_MISC && fld_hi != `MISC_MACRO &&
          fld_hi != `MISC_DELAY) begin
        misc_index_out <= fld_hi;
        misc_param_out <= fld_lo;
      end
      te_link_strobe_out <= pop &&
        (sub == `SUB_TE1 || sub == `SUB_TE2);
      if (pop && (sub == `SUB_TE1 || sub == `SUB_TE2)) begin
        te_link_unit_out <= (sub == `SUB_TE2);
        te_link_offset_out <= fld_hi;
        te_link_value_out <= fld_lo;
      end
    end
  end

  // apb slave; table data waits for an idle interpreter
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      run_q <= `CTRL_RESET;
      mac_addr_q <= {`MACRO_AW{1'b0}};
      cfg_addr_q <= {`CFG_AW{1'b0}};
      cfg_ok_q <= 1'b0;
    end else begin
      // read data registered one cycle after returning to idle
      cfg_ok_q <= (st_q == S_IDLE);
      pready_out <= apb_acc && (!is_cfg_data ||
        (cfg_ok_q && st_q == S_IDLE));
      pslverr_out <= apb_acc && !mapped;
      if (apb_acc) begin
        case (paddr_in)
          `REG_CTRL: prdata_out <= {31'h0000_0000, run_q};
          `REG_STATUS: prdata_out <= {8'h00, delay_q, 4'h0, st_q,
            1'b0, count_q};
          `REG_HISTORY: prdata_out <= hist_q;
          `REG_MACRO_ADDR: prdata_out <= {23'h00_0000, mac_addr_q};
          `REG_CFG_ADDR: prdata_out <= {23'h00_0000, cfg_addr_q};
          `REG_CFG_DATA: prdata_out <= {24'h00_0000, cfg_vote};
          default: prdata_out <= 32'h0000_0000;
        endcase
      end
      if (apb_wr && paddr_in == `REG_CTRL) begin
        run_q <= pwdata_in[`CTRL_RUN_BIT];
      end
      // address registers step after each data write
      if (apb_wr && paddr_in == `REG_MACRO_ADDR) begin
        mac_addr_q <= pwdata_in[`MACRO_AW-1:0];
      end else if (apb_mac_we) begin
        mac_addr_q <= mac_addr_q + 9'h001;
      end
      if (apb_wr && paddr_in == `REG_CFG_ADDR) begin
        cfg_addr_q <= pwdata_in[`CFG_AW-1:0];
      end else if (apb_cfg_we) begin
        cfg_addr_q <= cfg_addr_q + 9'h001;
      end
    end
  end

endmodule // serial_command_interpreter

`default_nettype wire

/* File: verif/cmd_source.sv */
`default_nettype none
// spacecraft bus side: hands command words over one at a time
module cmd_source (
  input wire logic clk_in, // bench clock
  output logic valid_out, // word strobe
  output logic [15:0] word_out // word lines
);
  timeunit 1ns;
  timeprecision 1ps;
  // lines idle low until the first word
  initial begin
    valid_out = 1'b0;
    word_out = 16'h0000;
  end
  // one word per strobe, whole 16 bits, msb 15
  task automatic send(input logic [15:0] w);
    @(posedge clk_in);
    valid_out <= 1'b1;
    word_out <= w;
    @(posedge clk_in);
    valid_out <= 1'b0;
    // lines are not held after the strobe, so show garbage
    word_out <= ~w;
  endtask
endmodule // cmd_source
`default_nettype wire

/* File: verif/serial_command_interpreter_chk.sv */
`include "cmd_interp_defines.vh"
`default_nettype none
module serial_command_interpreter_chk (
  input wire logic mclk_in, // clock
  input wire logic reset_n_in, // reset, active low
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic [7:0] paddr_in, // apb address
  input wire logic pready_out, // apb ready
  input wire logic pslverr_out, // apb error
  input wire logic cmd_valid_in, // word strobe
  input wire logic cmd_dropped_out, // word lost
  input wire logic misc_strobe_out, // handler pulse
  input wire logic [4:0] misc_index_out, // handler index
  input wire logic [7:0] misc_param_out, // handler parameter
  input wire logic te_link_strobe_out, // camera forward
  input wire logic [4:0] te_link_offset_out, // forwarded offset
  input wire logic [7:0] te_link_value_out // forwarded value
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // access phase of a transfer
  sequence s_access;
    psel_in && penable_in;
  endsequence
  // access still waiting; cfg data may stall while busy
  sequence s_wait;
    s_access ##0 (!pready_out && paddr_in != `REG_CFG_DATA);
  endsequence
  a_ready_late: assert property (s_wait |=> pready_out)
    else $error("ready late");
  a_ready_cause: assert property (pready_out |-> s_access)
    else $error("ready without access");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_misc_pulse: assert property (
    misc_strobe_out |=> !misc_strobe_out)
    else $error("misc strobe held");
  a_misc_hold: assert property (
    !misc_strobe_out |-> $stable(misc_index_out)
    && $stable(misc_param_out)) else $error("misc moved");
  a_te_pulse: assert property (
    te_link_strobe_out |=> !te_link_strobe_out)
    else $error("camera strobe held");
  a_te_hold: assert property (
    !te_link_strobe_out |-> $stable(te_link_offset_out)
    && $stable(te_link_value_out)) else $error("camera moved");
  a_drop_cause: assert property (
    cmd_dropped_out |-> $past(cmd_valid_in))
    else $error("drop without word");
endmodule // serial_command_interpreter_chk
`default_nettype wire

/* File: verif/serial_command_interpreter_tb_top.sv */
`default_nettype none
module serial_command_interpreter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0; // clock and reset
  logic psel = 0, pen = 0, pwr = 0; // apb controls
  logic [7:0] paddr = 0; // apb address
  logic [31:0] pwd = 0, prd; // apb data
  logic prdy, perr; // apb answer
  logic tick = 0, btv = 0, mtv = 0, inh = 0, hold = 0; // controls
  logic [7:0] bt = 0, mt = 0; // token values
  logic ms, ts, tu, dr; // strobes and camera unit out
  logic [4:0] mi, to; // index, offset
  logic [7:0] mp, tv; // param, value
  logic [31:0] r; // last read
  int n_errors = 0, samples_checked = 0, drops = 0;
  logic [12:0] misc_seen; // last {index,param}
  logic [13:0] te_seen; // last {unit,offset,value}
  logic cv; // command word strobe
  logic [15:0] cw; // command word
  cmd_source src_inst (.clk_in(clk), .valid_out(cv), .word_out(cw));
  serial_command_interpreter serial_command_interpreter_inst (
    .mclk_in(clk), .reset_n_in(rst_n), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .sched_tick_in(tick),
    .cmd_valid_in(cv), .cmd_word_in(cw),
    .bus_token_valid_in(btv), .bus_token_in(bt),
    .monitor_token_valid_in(mtv), .monitor_token_in(mt),
    .sot_inhibit_in(inh), .tp_hold_in(hold),
    .misc_strobe_out(ms), .misc_index_out(mi), .misc_param_out(mp),
    .te_link_strobe_out(ts), .te_link_unit_out(tu),
    .te_link_offset_out(to), .te_link_value_out(tv),
    .cmd_dropped_out(dr));
  always #2 clk = ~clk;
  // capture one-cycle pulses as they pass
  always @(posedge clk) begin
    if (ms === 1'b1) misc_seen <= {mi, mp};
    if (ts === 1'b1) te_seen <= {tu, to, tv};
    if (dr === 1'b1) drops <= drops + 1;
  end
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL %s exp %h got %h", nm, e, s);
    end
  endtask
  // one apb transfer; waits for ready, never a fixed count
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic e);
    int n;
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1;
    // ready sampled at the rising edge; data taken at that edge
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    if (n == 3000) begin n_errors++; stop_test(); end
    r = prd;
    chk("slverr", e, perr);
    psel <= 0;
    pen <= 0;
  endtask
  // scheduler pulse, then poll status until idle again
  task automatic run_tick;
    int n;
    @(posedge clk) tick <= 1;
    @(posedge clk) tick <= 0;
    for (n = 0; n < 200; n++) begin
      apb(0, 8'h04, 0, 0);
      if (r[11:8] === 4'h0) break;
    end
    if (n == 200) begin n_errors++; stop_test(); end
  endtask
  task automatic cfg_wr(input logic [8:0] a, input logic [7:0] d);
    apb(1, 8'h14, a, 0);
    apb(1, 8'h18, d, 0);
  endtask
  task automatic cfg_rd(input logic [8:0] a, input logic [7:0] e);
    apb(1, 8'h14, a, 0);
    apb(0, 8'h18, 0, 0);
    chk("cfg byte", e, r[7:0]);
  endtask
  // macro store: header word then one command from address a
  task automatic mac_wr(input logic [8:0] a, input logic [15:0] h, w);
    apb(1, 8'h0c, a, 0);
    apb(1, 8'h10, h, 0);
    apb(1, 8'h10, w, 0);
  endtask
  // one token pulse, from the monitor when m is set
  task automatic token(input logic m, input logic [7:0] v);
    @(posedge clk);
    if (m) begin
      mtv <= 1;
      mt <= v;
    end else begin
      btv <= 1;
      bt <= v;
    end
    @(posedge clk);
    btv <= 0;
    mtv <= 0;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    apb(0, 8'h00, 0, 0);
    chk("ctrl reset", 1, r[0]);
    apb(0, 8'h40, 0, 1);
    chk("unmapped read", 0, r);
    // copy source 2 into dest 6: both halves move together
    cfg_wr(9'h040, 8'h11);
    cfg_wr(9'h060, 8'h22);
    src_inst.send(16'hc602);
    run_tick();
    cfg_rd(9'h0c0, 8'h11);
    cfg_rd(9'h0e0, 8'h22);
    // camera one update, offset 5, value a7
    src_inst.send(16'h45a7);
    run_tick();
    chk("te fwd", {1'b0, 5'd5, 8'ha7}, te_seen);
    cfg_rd(9'h0e5, 8'ha7);
    src_inst.send(16'he35a);
    run_tick();
    chk("misc", {5'd3, 8'h5a}, misc_seen);
    // rom macros: cutoff runs one misc, token 5 another
    mac_wr(9'h110, 16'h0001, 16'he433);
    mac_wr(9'h150, 16'h0001, 16'he955);
    // fill the queue while held, one more is lost
    hold <= 1;
    repeat (65) src_inst.send(16'ha000);
    repeat (2) @(posedge clk);
    chk("drops", 1, drops);
    // a cutoff macro cannot fit the full queue
    token(0, 8'h01);
    run_tick();
    apb(0, 8'h04, 0, 0);
    chk("held count", 64, r[6:0]);
    hold <= 0;
    run_tick();
    apb(0, 8'h04, 0, 0);
    chk("empty", 0, r[6:0]);
    token(0, 8'h01);
    run_tick();
    chk("macro cmd", {5'd4, 8'h33}, misc_seen);
    // start token skipped under inhibit
    inh <= 1;
    token(1, 8'h03);
    run_tick();
    apb(0, 8'h08, 0, 0);
    chk("history", 24'h010183, r[23:0]);
    // two tick delay parks the camera two update
    src_inst.send(16'hfe02);
    src_inst.send(16'h6601);
    run_tick();
    apb(0, 8'h04, 0, 0);
    chk("delay held", 1, r[6:0]);
    run_tick();
    apb(0, 8'h04, 0, 0);
    chk("delay count", 1, r[6:0]);
    run_tick();
    chk("te2 fwd", {1'b1, 5'd6, 8'h01}, te_seen);
    // user macro of 4 bytes goes ahead of the queued word
    mac_wr(9'h020, 16'h0004, 16'he511);
    apb(1, 8'h10, 32'he622, 0);
    src_inst.send(16'he120);
    src_inst.send(16'he733);
    run_tick();
    chk("macro order", {5'd7, 8'h33}, misc_seen);
    src_inst.send(16'he120);
    run_tick();
    chk("macro again", {5'd6, 8'h22}, misc_seen);
    // a low priority token waits behind queued words
    token(1, 8'h05);
    src_inst.send(16'hea44);
    run_tick();
    chk("queue first", {5'd10, 8'h44}, misc_seen);
    run_tick();
    chk("token macro", {5'd9, 8'h55}, misc_seen);
    apb(0, 8'h08, 0, 0);
    chk("history 4", 32'h01018305, r);
    stop_test();
  end
endmodule // serial_command_interpreter_tb_top
bind serial_command_interpreter serial_command_interpreter_chk chk_inst (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .paddr_in(paddr_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .cmd_valid_in(cmd_valid_in), .cmd_dropped_out(cmd_dropped_out),
  .misc_strobe_out(misc_strobe_out), .misc_index_out(misc_index_out),
  .misc_param_out(misc_param_out),
  .te_link_strobe_out(te_link_strobe_out),
  .te_link_offset_out(te_link_offset_out),
  .te_link_value_out(te_link_value_out));
`default_nettype wire
